/* File: verilog/dltc_defs.svh */
// offsets, fields, reset values and sizes of the transmit link count control
`ifndef DLTC_DEFS_SVH
`define DLTC_DEFS_SVH

`define DLTC_ADDR_W          8
`define DLTC_OFF_MODE        8'h13
`define DLTC_OFF_COUNT       8'h14
`define DLTC_OFF_BUF_DATA    8'h20
`define DLTC_OFF_STATUS      8'h21
`define DLTC_OFF_CTRL        8'h22
`define DLTC_MODE_BIT        0
`define DLTC_ABORT_SUPP_BIT  6
`define DLTC_BUFSEL_BIT      7
`define DLTC_CTRL_START_BIT  0
`define DLTC_CTRL_PTR_CLR    1
`define DLTC_MODE_RST        8'h00
`define DLTC_COUNT_RST       8'h00
`define DLTC_BUF_BYTES       96
`define DLTC_ABORT_BYTE      8'hFF
`define DLTC_ABORT_LEN       7'h02
`define DLTC_BYTE_TIME       7'h08

`endif

/* File: verilog/dltc_pkg.sv */
// types of the transmit link count control
package dltc_pkg;
	typedef enum logic [1:0] {
		DLTC_IDLE,
		DLTC_ABORT,
		DLTC_SEND
	} dltc_state_t;
endpackage

/* File: verilog/dltc_buffer.sv */
// one message buffer: byte array written by software, read by the sender
`include "dltc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dltc_buffer #(
	parameter int DEPTH = `DLTC_BUF_BYTES,
	parameter int AW    = 7
) (
	// clock
	input  wire logic          clk_i,
	// write side
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [7:0]    wr_data_i,
	// read side
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [7:0]    rd_data_o
);
	logic [7:0] mem [DEPTH];

	// elaboration check: every entry must be addressable
	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("buffer depth exceeds address range");
	end

	always_ff @(posedge clk_i) begin
		if (wr_en_i && (int'(wr_addr_i) < DEPTH))
			mem[wr_addr_i] <= wr_data_i;
	end

	always_comb begin
		rd_data_o = (int'(rd_addr_i) < DEPTH) ? mem[rd_addr_i] : 8'h00;
	end
endmodule
`default_nettype wire

/* File: verilog/dltc_top.sv */
// transmit link count control: mode, buffer select, counter, end of transfer
// How it works
// - mode bit 0 low selects message signaling, high selects bit signaling.
// - count register bit 7 picks transmit buffer 0 or buffer 1.
// - each transfer start copies the count field into the internal counter.
// - done interrupt after full message or after programmed repetitions sent.
// - each of the two transmit buffers holds up to 96 bytes.
// - bit mode with count zero repeats forever, never raises done.
// - message-to-bit mode change inserts abort unless suppression bit set.
//
// Local design decision: the plain strobed port.
`include "dltc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dltc_top #(
	parameter int BUF_BYTES = `DLTC_BUF_BYTES
) (
	// clock and reset
	input  wire logic                    MCLK_I,
	input  wire logic                    RST_I,
	// register port
	input  wire logic [`DLTC_ADDR_W-1:0] ADDR_I,
	input  wire logic [7:0]              WDATA_I,
	input  wire logic                    WR_I,
	input  wire logic                    RD_I,
	output logic      [7:0]              RDATA_O,
	// serial link out
	output logic                         LINK_BIT_O,
	output logic                         LINK_VALID_O,
	// mode and status
	output logic                         BIT_SIGNALING_MODE_O,
	output logic                         BUSY_O,
	output logic                         TX_TRANSFER_DONE_IRQ_O
);
	localparam int AW = 7;

	logic [7:0]              mode_reg_ff;
	logic [7:0]              tx_link_count_select_ff;
	logic [6:0]              wptr0_ff, wptr1_ff;
	logic [6:0]              counter_ff;
	logic [6:0]              rptr_ff;
	logic [6:0]              abort_cnt_ff;
	logic                    buf_sel_ff;
	logic                    cur_bit_mode_ff;
	logic [7:0]              shift_ff;
	logic [2:0]              bit_cnt_ff;
	logic                    done_ff;
	logic                    abort_pend_ff;
	logic                    start_req;
	logic [7:0]              rd_arr [2];
	logic [7:0]              cur_byte;
	logic                    wr_buf;
	dltc_pkg::dltc_state_t   state_ff;

	// elaboration check: count field is seven bits wide
	if (BUF_BYTES < 1 || BUF_BYTES > 127) begin : g_bad_depth
		$error("BUF_BYTES out of range");
	end

	wire message_signaling_mode = ~mode_reg_ff[`DLTC_MODE_BIT];
	wire bit_signaling_mode     = mode_reg_ff[`DLTC_MODE_BIT];
	wire [6:0] count_field      = tx_link_count_select_ff[6:0];
	wire sel_buf                = tx_link_count_select_ff[`DLTC_BUFSEL_BIT];

	assign wr_buf    = WR_I && (ADDR_I == `DLTC_OFF_BUF_DATA);
	assign start_req = WR_I && (ADDR_I == `DLTC_OFF_CTRL)
		&& WDATA_I[`DLTC_CTRL_START_BIT];

	// two message buffers
	genvar g;
	for (g = 0; g < 2; g++) begin : g_buf
		dltc_buffer #(.DEPTH(BUF_BYTES), .AW(AW)) u_buf (
			.clk_i     (MCLK_I),
			.wr_en_i   (wr_buf && (sel_buf == 1'(g))),
			.wr_addr_i (g == 0 ? wptr0_ff : wptr1_ff),
			.wr_data_i (WDATA_I),
			.rd_addr_i (rptr_ff),
			.rd_data_o (rd_arr[g])
		);
	end
	assign cur_byte = rd_arr[buf_sel_ff];

	// mode and count registers
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			mode_reg_ff             <= `DLTC_MODE_RST;
			tx_link_count_select_ff <= `DLTC_COUNT_RST;
		end else if (WR_I) begin
			if (ADDR_I == `DLTC_OFF_MODE)
				mode_reg_ff <= WDATA_I;
			if (ADDR_I == `DLTC_OFF_COUNT)
				tx_link_count_select_ff <= WDATA_I;
		end
	end

	// buffer write pointers, one per buffer
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			wptr0_ff <= 7'h00;
			wptr1_ff <= 7'h00;
		end else if (WR_I && (ADDR_I == `DLTC_OFF_CTRL)
			&& WDATA_I[`DLTC_CTRL_PTR_CLR]) begin
			if (sel_buf)
				wptr1_ff <= 7'h00;
			else
				wptr0_ff <= 7'h00;
		end else if (wr_buf) begin
			if (sel_buf && int'(wptr1_ff) < BUF_BYTES)
				wptr1_ff <= wptr1_ff + 7'h01;
			else if (!sel_buf && int'(wptr0_ff) < BUF_BYTES)
				wptr0_ff <= wptr0_ff + 7'h01;
		end
	end

	// abort request on message-to-bit mode change
	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			abort_pend_ff <= 1'b0;
		else if (WR_I && (ADDR_I == `DLTC_OFF_MODE)
			&& message_signaling_mode && WDATA_I[`DLTC_MODE_BIT]
			&& !WDATA_I[`DLTC_ABORT_SUPP_BIT])
			abort_pend_ff <= 1'b1;
		else if (state_ff == dltc_pkg::DLTC_ABORT)
			abort_pend_ff <= 1'b0;
	end

	// transfer engine
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			state_ff        <= dltc_pkg::DLTC_IDLE;
			counter_ff      <= 7'h00;
			rptr_ff         <= 7'h00;
			abort_cnt_ff    <= 7'h00;
			buf_sel_ff      <= 1'b0;
			cur_bit_mode_ff <= 1'b0;
			shift_ff        <= 8'h00;
			bit_cnt_ff      <= 3'h0;
			done_ff         <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			unique case (state_ff)
			dltc_pkg::DLTC_IDLE: begin
				if (abort_pend_ff) begin
					state_ff     <= dltc_pkg::DLTC_ABORT;
					abort_cnt_ff <= `DLTC_ABORT_LEN;
					shift_ff     <= `DLTC_ABORT_BYTE;
					bit_cnt_ff   <= 3'h0;
				end else if (start_req) begin
					state_ff        <= dltc_pkg::DLTC_SEND;
					counter_ff      <= count_field;
					buf_sel_ff      <= sel_buf;
					cur_bit_mode_ff <= bit_signaling_mode;
					rptr_ff         <= 7'h00;
					bit_cnt_ff      <= 3'h0;
				end
			end
			dltc_pkg::DLTC_ABORT: begin
				shift_ff   <= {shift_ff[6:0], 1'b1};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == 3'h7) begin
					shift_ff     <= `DLTC_ABORT_BYTE;
					abort_cnt_ff <= abort_cnt_ff - 7'h01;
					if (abort_cnt_ff == 7'h01)
						state_ff <= dltc_pkg::DLTC_IDLE;
				end
			end
			dltc_pkg::DLTC_SEND: begin
				// msb leaves straight from the buffer, the rest from here
				if (bit_cnt_ff == 3'h0)
					shift_ff <= {cur_byte[6:0], 1'b0};
				else
					shift_ff <= {shift_ff[6:0], 1'b0};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == 3'h7) begin
					rptr_ff <= rptr_ff + 7'h01;
					if (!cur_bit_mode_ff) begin
						// one byte sent
						counter_ff <= counter_ff - 7'h01;
						if (counter_ff <= 7'h01 || int'(rptr_ff) + 1 >= BUF_BYTES) begin
							state_ff <= dltc_pkg::DLTC_IDLE;
							done_ff  <= 1'b1;
						end
					end else if (rptr_ff == 7'h00) begin
						// one-byte bit-mode message: one repetition done
						rptr_ff <= 7'h00;
						if (counter_ff != 7'h00) begin
							counter_ff <= counter_ff - 7'h01;
							if (counter_ff == 7'h01) begin
								state_ff <= dltc_pkg::DLTC_IDLE;
								done_ff  <= 1'b1;
							end
						end
					end
				end
			end
			default: state_ff <= dltc_pkg::DLTC_IDLE;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			LINK_BIT_O             <= 1'b0;
			LINK_VALID_O           <= 1'b0;
			BIT_SIGNALING_MODE_O   <= 1'b0;
			BUSY_O                 <= 1'b0;
			TX_TRANSFER_DONE_IRQ_O <= 1'b0;
		end else begin
			LINK_BIT_O   <= (state_ff == dltc_pkg::DLTC_SEND && bit_cnt_ff == 3'h0)
				? cur_byte[7] : shift_ff[7];
			LINK_VALID_O <= (state_ff != dltc_pkg::DLTC_IDLE);
			BIT_SIGNALING_MODE_O   <= bit_signaling_mode;
			BUSY_O                 <= (state_ff != dltc_pkg::DLTC_IDLE);
			TX_TRANSFER_DONE_IRQ_O <= done_ff;
		end
	end

	// read port: data one cycle after the strobe
	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			RDATA_O <= 8'h00;
		else if (RD_I) begin
			unique case (ADDR_I)
			`DLTC_OFF_MODE:   RDATA_O <= mode_reg_ff;
			`DLTC_OFF_COUNT:  RDATA_O <= tx_link_count_select_ff;
			`DLTC_OFF_STATUS: RDATA_O <= {abort_pend_ff, counter_ff};
			default:          RDATA_O <= 8'h00;
			endcase
		end else
			RDATA_O <= 8'h00;
	end
endmodule
`default_nettype wire

/* File: verif/dltc_properties.sv */
// port checker of the transmit link count control
`timescale 1ns/1ps
`default_nettype none
module dltc_properties (
	// clock and reset
	input wire logic       MCLK_I,
	input wire logic       RST_I,
	// register port
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	// link and status
	input wire logic       LINK_BIT_O,
	input wire logic       LINK_VALID_O,
	input wire logic       BIT_SIGNALING_MODE_O,
	input wire logic       BUSY_O,
	input wire logic       TX_TRANSFER_DONE_IRQ_O
);
	logic [7:0] cnt_ff;
	logic       supp_ff;
	always_ff @(posedge MCLK_I) begin
		if (RST_I) cnt_ff <= 8'h00;
		else if (WR_I && ADDR_I == 8'h14) cnt_ff <= WDATA_I;
	end
	always_ff @(posedge MCLK_I) begin
		if (RST_I) supp_ff <= 1'b0;
		else if (WR_I && ADDR_I == 8'h13) supp_ff <= WDATA_I[6];
	end
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	a_mode_follow: assert property (WR_I && ADDR_I == 8'h13
		|-> ##2 BIT_SIGNALING_MODE_O == $past(WDATA_I[0], 2))
		else $error("mode");
	a_count_read: assert property (RD_I && ADDR_I == 8'h14
		|=> RDATA_O == cnt_ff) else $error("count readback");
	a_endless_quiet: assert property (BIT_SIGNALING_MODE_O
		&& cnt_ff[6:0] == 7'h00 |-> !TX_TRANSFER_DONE_IRQ_O)
		else $error("done in endless mode");
	a_abort_sent: assert property ($rose(BIT_SIGNALING_MODE_O)
		&& !supp_ff && !BUSY_O |-> ##[0:4] LINK_VALID_O && LINK_BIT_O)
		else $error("abort missing");
	a_abort_held: assert property ($rose(BIT_SIGNALING_MODE_O)
		&& supp_ff && !BUSY_O |-> !LINK_VALID_O [*8])
		else $error("abort not suppressed");
	a_whole_byte: assert property ($rose(LINK_VALID_O)
		|-> LINK_VALID_O [*8]) else $error("short byte");
	a_done_pulse: assert property (TX_TRANSFER_DONE_IRQ_O
		|=> !TX_TRANSFER_DONE_IRQ_O) else $error("done too long");
	a_done_busy: assert property (TX_TRANSFER_DONE_IRQ_O
		|-> $past(BUSY_O)) else $error("done while idle");
endmodule
bind dltc_top dltc_properties u_props (.MCLK_I(MCLK_I), .RST_I(RST_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
	.RDATA_O(RDATA_O), .LINK_BIT_O(LINK_BIT_O), .LINK_VALID_O(LINK_VALID_O),
	.BIT_SIGNALING_MODE_O(BIT_SIGNALING_MODE_O), .BUSY_O(BUSY_O),
	.TX_TRANSFER_DONE_IRQ_O(TX_TRANSFER_DONE_IRQ_O));
`default_nettype wire

/* File: verif/dltc_remote.sv */
// remote terminal model: gathers link bits into bytes
`timescale 1ns/1ps
`default_nettype none
module dltc_remote (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// link in
	input  wire logic        bit_i,
	input  wire logic        valid_i,
	// gathered bytes
	output logic      [7:0]  byte_o,
	output logic      [15:0] count_o
);
	logic [7:0] sh_ff;
	logic [2:0] n_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i || !valid_i) n_ff <= 3'h0;
		else n_ff <= n_ff + 3'h1;
	end
	always_ff @(posedge clk_i) begin
		if (valid_i) sh_ff <= {sh_ff[6:0], bit_i};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) count_o <= 16'h0000;
		else if (valid_i && n_ff == 3'h7) count_o <= count_o + 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		if (valid_i && n_ff == 3'h7) byte_o <= {sh_ff[6:0], bit_i};
	end
endmodule
`default_nettype wire

/* File: verif/test_datalink_tx_count_control.sv */
// self-checking bench of the transmit link count control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module test_datalink_tx_count_control;
	logic        clk = 0, rst = 1, wr_s = 0, rd_s = 0;
	logic [7:0]  addr = 8'h00, wd = 8'h00, rdata, v, rbyte;
	logic        lbit, lval, mode, busy, irq;
	logic [15:0] rcnt, n0;
	int          miscompares = 0, tests_run = 0, cyc = 0, i;
	initial forever #25 clk = ~clk;
	dltc_top dut (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
		.WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .LINK_BIT_O(lbit),
		.LINK_VALID_O(lval), .BIT_SIGNALING_MODE_O(mode), .BUSY_O(busy),
		.TX_TRANSFER_DONE_IRQ_O(irq));
	dltc_remote far (.clk_i(clk), .rst_i(rst), .bit_i(lbit), .valid_i(lval),
		.byte_o(rbyte), .count_o(rcnt));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	// select buffer and count, rewind its write pointer
	task automatic load(input logic [7:0] c);
		wr(8'h14, c);
		wr(8'h22, 8'h02);
	endtask
	task automatic go();
		n0 = rcnt;
		wr(8'h22, 8'h01);
		for (i = 0; i < 2000 && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(irq, 1'b1)
	endtask
	task automatic t_msg();
		rd(8'h14);
		`CHK(v, 8'h00)
		rd(8'h30);
		`CHK(v, 8'h00)
		load(8'h02);
		wr(8'h20, 8'hA5);
		wr(8'h20, 8'h3C);
		go();
		`CHK(rcnt, n0 + 16'h2)
		`CHK(rbyte, 8'h3C)
		rd(8'h14);
		`CHK(v, 8'h02)
		$display("message test done");
	endtask
	task automatic t_bufsel();
		load(8'h81);
		wr(8'h20, 8'h5A);
		go();
		`CHK(rbyte, 8'h5A)
		wr(8'h14, 8'h01);
		go();
		`CHK(rbyte, 8'hA5)
		load(8'hE0);
		for (int k = 0; k < 97; k++) wr(8'h20, 8'(k));
		go();
		`CHK(rcnt, n0 + 16'h0060)
		`CHK(rbyte, 8'h5F)
		$display("buffer test done");
	endtask
	task automatic t_mode();
		n0 = rcnt;
		wr(8'h13, 8'h01);
		rd(8'h21);
		`CHK(v, 8'h80)
		repeat (30) @(posedge clk);
		#1 `CHK(mode, 1'b1)
		`CHK(rcnt, n0 + 16'h2)
		`CHK(rbyte, 8'hFF)
		wr(8'h13, 8'h00);
		wr(8'h13, 8'h41);
		n0 = rcnt;
		repeat (30) @(posedge clk);
		#1 `CHK(rcnt, n0)
		wr(8'h14, 8'h02);
		go();
		`CHK(rcnt, n0 + 16'h2)
		`CHK(rbyte, 8'hA5)
		wr(8'h14, 8'h00);
		wr(8'h22, 8'h01);
		repeat (300) @(posedge clk);
		#1 `CHK(busy, 1'b1)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h13);
		`CHK(v, 8'h00)
		`CHK(busy, 1'b0)
		$display("mode test done");
	endtask
	task automatic complete_run();
		$display("%0d compared, %0d mismatched", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_msg();
		t_bufsel();
		t_mode();
		complete_run();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			miscompares++;
			complete_run();
		end
	end
endmodule
`default_nettype wire
